// ===== logic/sldec_cfg.svh
// register offsets, field positions, reset values and counts for the deframer error control block
// assumes a 12-bit register address and 8-bit register data
`ifndef SLDEC_CFG_SVH
`define SLDEC_CFG_SVH

// register offsets
`define SLDEC_ADDR_CTRL1       12'h476
`define SLDEC_ADDR_CTRL2       12'h477
`define SLDEC_ADDR_MFGRP       12'h478
`define SLDEC_ADDR_THRES       12'h47C
`define SLDEC_ADDR_MASK        12'h47D
`define SLDEC_ADDR_LANE0       12'h480
// upper nine address bits shared by the eight lane counter control registers
`define SLDEC_ADDR_LANE_HI     9'h090

// field positions
`define SLDEC_CTRL1_SKIP       1
`define SLDEC_CTRL1_CHKSEL     0
`define SLDEC_CTRL2_TEST       7
`define SLDEC_CTRL2_REPEAT     5
`define SLDEC_CTRL2_QUEUE      4
`define SLDEC_CTRL2_AUTOCLR    3
`define SLDEC_LANE_EN_MSB      5
`define SLDEC_LANE_EN_LSB      3

// reset values
`define SLDEC_RST_BYTE         8'h00
`define SLDEC_RST_MFGRP        8'h01
`define SLDEC_RST_THRES        8'hFF
`define SLDEC_RST_MASK         3'h7
`define SLDEC_RST_LANE_EN      3'h7

// sizes and counts
`define SLDEC_NUM_LANES        8
`define SLDEC_NUM_TYPES        3
`define SLDEC_CNT_MAX          8'hFF
`define SLDEC_SYNC_CYCLES      3'h4
`define SLDEC_PEND_MAX         8'hFF
`define SLDEC_CHK_IDX          4'hD

// per-octet field boundaries, a set bit marks the lowest bit of a field
`define SLDEC_SPLIT_0          8'h01
`define SLDEC_SPLIT_1          8'h11
`define SLDEC_SPLIT_2          8'h61
`define SLDEC_SPLIT_3          8'h81
`define SLDEC_SPLIT_7          8'h41
`define SLDEC_SPLIT_8          8'h21
`define SLDEC_SPLIT_9          8'h21
`define SLDEC_SPLIT_10         8'h81
`define SLDEC_SPLIT_WHOLE      8'h01

`endif

// ===== logic/sldec_pkg.sv
// types shared by the deframer error control block
// assumes sldec_cfg.svh carries the numeric constants
package sldec_pkg;

  typedef logic [7:0]  sldec_byte_t;
  typedef logic [2:0]  sldec_tri_t;

  // receive sequencing states
  typedef enum logic [2:0] {
    SLDEC_ST_OFF,
    SLDEC_ST_CGS,
    SLDEC_ST_ILAS,
    SLDEC_ST_ILAS_LOOP,
    SLDEC_ST_DATA,
    SLDEC_ST_PATTERN
  } sldec_state_e;

endpackage

// ===== logic/sldec_lane_counters.sv
// one lane of error counters: disparity, not-in-table, unexpected control character
// assumes error strobes are one-cycle pulses synchronous to clock
`timescale 1ns/1ns
`include "sldec_cfg.svh"

module sldec_lane_counters (
  // clock, reset, enable
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                soft_reset,
  // per-type controls, index 0 disparity, 1 not-in-table, 2 unexpected char
  input  wire sldec_pkg::sldec_tri_t err_in,
  input  wire sldec_pkg::sldec_tri_t cnt_en,
  input  wire sldec_pkg::sldec_tri_t sync_mask,
  input  wire logic                auto_clear,
  input  wire sldec_pkg::sldec_byte_t threshold,
  // results
  output sldec_pkg::sldec_tri_t    hit,
  output logic [23:0]              count
);
  import sldec_pkg::*;

  genvar t;
  generate
    for (t = 0; t < `SLDEC_NUM_TYPES; t++) begin : g_type
      sldec_byte_t cnt;
      sldec_byte_t next_cnt;
      logic        hit_q;
      logic        next_hit;
      logic        inc;
      logic        reach;
      sldec_byte_t cnt_plus;

      // count, compare and optional self clear
      always_comb begin
        inc      = err_in[t] & cnt_en[t] & (cnt != `SLDEC_CNT_MAX);
        cnt_plus = cnt + 8'h01;
        reach    = inc & (cnt_plus == threshold);
        next_hit = ~soft_reset & reach;
        if (soft_reset) begin
          next_cnt = `SLDEC_RST_BYTE;
        end else if (reach & auto_clear & sync_mask[t]) begin
          next_cnt = `SLDEC_RST_BYTE;
        end else if (inc) begin
          next_cnt = cnt_plus;
        end else begin
          next_cnt = cnt;
        end
      end

      // counter storage
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          cnt   <= `SLDEC_RST_BYTE;
          hit_q <= 1'b0;
        end else if (ce) begin
          cnt   <= next_cnt;
          hit_q <= next_hit;
        end
      end

      assign hit[t]           = hit_q;
      assign count[t*8 +: 8]  = cnt;
    end
  endgenerate

endmodule

// ===== logic/sldec_top.sv
// receive deframer configuration, sequencing, checksum and error monitoring
// assumes lane decoders give error pulses and alignment logic gives sync, multiframe and config octets
//
// Summary of operation
// - with the skip bit set and both test bits zero the receiver goes from code group sync straight to user data.
// - with checksum method zero the checksum is the sum of the individual configuration fields.
// - with checksum method one the checksum is the sum of the whole configuration octets.
// - with the alignment test bit set the alignment sequence is expected to repeat forever.
// - the repeat pattern test runs after alignment only when the alignment test bit is zero.
// - without queued reporting, errors hitting in one cycle give one sync request.
// - with queued reporting, every hit is counted and signalled on sync request one by one.
// - with auto clear only the counter that raised sync request returns to zero.
// - the alignment sequence lasts four multiframes per unit of the multiframe count, reset one.
// - each lane counts three error kinds and flags equality with the threshold.
// - sync request asserts on a threshold hit whose mask bit is set, bit two disparity.
// - lane counter enable bits are bit two unexpected char, bit one table, bit zero disparity.
// - soft reset clears counters, sync reporting, sequencing and checksum and stops reception; registers and lane enables keep their values.
`timescale 1ns/1ns
`include "sldec_cfg.svh"

module sldec_top (
  // clock, reset, enable
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  // register port
  input  wire logic [11:0]            reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire sldec_pkg::sldec_byte_t reg_wdata,
  output sldec_pkg::sldec_byte_t      reg_rdata,
  output logic                        reg_rdata_valid,
  // deframer control
  input  wire logic                   soft_reset_bit,
  // link progress from alignment logic
  input  wire logic                   cgs_achieved,
  input  wire logic                   mf_boundary,
  // configuration octets received during alignment
  input  wire logic                   cfg_valid,
  input  wire logic [3:0]             cfg_index,
  input  wire sldec_pkg::sldec_byte_t cfg_octet,
  // lane error pulses, one bit per lane
  input  wire logic [7:0]             bad_disparity_error,
  input  wire logic [7:0]             not_in_table_error,
  input  wire logic [7:0]             unexpected_control_char_error,
  // status
  output logic                        rx_enable,
  output logic                        expect_ilas,
  output logic                        expect_user_data,
  output logic                        pattern_test_active,
  output logic                        chk_done,
  output logic                        chk_error,
  output logic [23:0]                 threshold_event,
  output logic                        sync_request_out
);
  import sldec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic        skip_alignment_seq, next_skip;
  logic        checksum_method_sel, next_chksel;
  logic        alignment_test_mode, next_test;
  logic        repeat_pattern_test_en, next_repeat;
  logic        queued_error_report, next_queue;
  logic        auto_clear_error_count, next_autoclr;
  sldec_byte_t alignment_multiframe_cnt, next_mfgrp;
  sldec_byte_t error_threshold_value, next_thres;
  sldec_tri_t  sync_request_error_mask, next_mask;
  sldec_byte_t lane_rd [`SLDEC_NUM_LANES];
  sldec_byte_t next_rdata;
  logic        lane_sel;

  assign lane_sel = (reg_addr[11:3] == `SLDEC_ADDR_LANE_HI);

  // write decode for the shared registers
  always_comb begin
    next_skip    = skip_alignment_seq;
    next_chksel  = checksum_method_sel;
    next_test    = alignment_test_mode;
    next_repeat  = repeat_pattern_test_en;
    next_queue   = queued_error_report;
    next_autoclr = auto_clear_error_count;
    next_mfgrp   = alignment_multiframe_cnt;
    next_thres   = error_threshold_value;
    next_mask    = sync_request_error_mask;
    if (reg_wr) begin
      case (reg_addr)
        `SLDEC_ADDR_CTRL1: begin
          next_skip   = reg_wdata[`SLDEC_CTRL1_SKIP];
          next_chksel = reg_wdata[`SLDEC_CTRL1_CHKSEL];
        end
        `SLDEC_ADDR_CTRL2: begin
          next_test    = reg_wdata[`SLDEC_CTRL2_TEST];
          next_repeat  = reg_wdata[`SLDEC_CTRL2_REPEAT];
          next_queue   = reg_wdata[`SLDEC_CTRL2_QUEUE];
          next_autoclr = reg_wdata[`SLDEC_CTRL2_AUTOCLR];
        end
        `SLDEC_ADDR_MFGRP: next_mfgrp = reg_wdata;
        `SLDEC_ADDR_THRES: next_thres = reg_wdata;
        `SLDEC_ADDR_MASK:  next_mask  = reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    next_rdata = `SLDEC_RST_BYTE;
    if (lane_sel) begin
      next_rdata = lane_rd[reg_addr[2:0]];
    end else begin
      case (reg_addr)
        `SLDEC_ADDR_CTRL1: begin
          next_rdata[`SLDEC_CTRL1_SKIP]   = skip_alignment_seq;
          next_rdata[`SLDEC_CTRL1_CHKSEL] = checksum_method_sel;
        end
        `SLDEC_ADDR_CTRL2: begin
          next_rdata[`SLDEC_CTRL2_TEST]    = alignment_test_mode;
          next_rdata[`SLDEC_CTRL2_REPEAT]  = repeat_pattern_test_en;
          next_rdata[`SLDEC_CTRL2_QUEUE]   = queued_error_report;
          next_rdata[`SLDEC_CTRL2_AUTOCLR] = auto_clear_error_count;
        end
        `SLDEC_ADDR_MFGRP: next_rdata = alignment_multiframe_cnt;
        `SLDEC_ADDR_THRES: next_rdata = error_threshold_value;
        `SLDEC_ADDR_MASK:  next_rdata[2:0] = sync_request_error_mask;
        default: ;
      endcase
    end
  end

  // register storage, not touched by soft reset so it can be set up under it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      skip_alignment_seq       <= 1'b0;
      checksum_method_sel      <= 1'b0;
      alignment_test_mode      <= 1'b0;
      repeat_pattern_test_en   <= 1'b0;
      queued_error_report      <= 1'b0;
      auto_clear_error_count   <= 1'b0;
      alignment_multiframe_cnt <= `SLDEC_RST_MFGRP;
      error_threshold_value    <= `SLDEC_RST_THRES;
      sync_request_error_mask  <= `SLDEC_RST_MASK;
      reg_rdata                <= `SLDEC_RST_BYTE;
      reg_rdata_valid          <= 1'b0;
    end else if (ce) begin
      skip_alignment_seq       <= next_skip;
      checksum_method_sel      <= next_chksel;
      alignment_test_mode      <= next_test;
      repeat_pattern_test_en   <= next_repeat;
      queued_error_report      <= next_queue;
      auto_clear_error_count   <= next_autoclr;
      alignment_multiframe_cnt <= next_mfgrp;
      error_threshold_value    <= next_thres;
      sync_request_error_mask  <= next_mask;
      reg_rdata                <= reg_rd ? next_rdata : reg_rdata;
      reg_rdata_valid          <= reg_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-lane counter control and error counters

  logic [23:0] hit_all;
  sldec_tri_t  mask_by_type;

  // mask bit order is reversed against the counter type order
  assign mask_by_type = {sync_request_error_mask[0], sync_request_error_mask[1],
                         sync_request_error_mask[2]};

  genvar l;
  generate
    for (l = 0; l < `SLDEC_NUM_LANES; l++) begin : g_lane
      sldec_tri_t en_q;
      sldec_tri_t next_en;
      sldec_tri_t hit_l;

      // lane counter enable write
      always_comb begin
        next_en = en_q;
        if (reg_wr && lane_sel && (reg_addr[2:0] == 3'(l))) begin
          next_en = reg_wdata[`SLDEC_LANE_EN_MSB:`SLDEC_LANE_EN_LSB];
        end
      end

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          en_q <= `SLDEC_RST_LANE_EN;
        end else if (ce) begin
          en_q <= next_en;
        end
      end

      assign lane_rd[l] = {2'b00, en_q, 3'b000};

      sldec_lane_counters u_cnt (
        .clock      (clock),
        .rst_n      (rst_n),
        .ce         (ce),
        .soft_reset (soft_reset_bit),
        .err_in     ({unexpected_control_char_error[l], not_in_table_error[l], bad_disparity_error[l]}),
        .cnt_en     (en_q),
        .sync_mask  (mask_by_type),
        .auto_clear (auto_clear_error_count),
        .threshold  (error_threshold_value),
        .hit        (hit_l),
        .count      ()
      );
      assign hit_all[l*3 +: 3] = hit_l;
    end
  endgenerate

  assign threshold_event = hit_all;

  ////////////////////////////////////////////////////////////////////////////
  // sync request reporting

  logic [23:0] sync_hits;
  logic [4:0]  hit_pop;
  sldec_byte_t pending, next_pending;
  logic [2:0]  sync_timer, next_timer;
  logic        next_sync;
  logic        start;
  logic [8:0]  pend_sum;
  logic [7:0]  add_cnt;

  // hits whose kind is enabled for sync request, then count and queue them
  always_comb begin
    sync_hits = hit_all & {`SLDEC_NUM_LANES{mask_by_type}};
    hit_pop   = 5'h00;
    for (int i = 0; i < `SLDEC_NUM_LANES * `SLDEC_NUM_TYPES; i++) begin
      hit_pop = hit_pop + {4'h0, sync_hits[i]};
    end
    add_cnt  = queued_error_report ? {3'b000, hit_pop}
                                   : {7'h00, |sync_hits};
    start    = (sync_timer == 3'h0) & ~sync_request_out & (pending != 8'h00);
    pend_sum = {1'b0, pending} + {1'b0, add_cnt} - {8'h00, start};
    if (soft_reset_bit) begin
      next_pending = `SLDEC_RST_BYTE;
    end else if (pend_sum > {1'b0, `SLDEC_PEND_MAX}) begin
      next_pending = `SLDEC_PEND_MAX;
    end else begin
      next_pending = pend_sum[7:0];
    end
    // each report holds sync request for a fixed span, then one idle cycle
    if (soft_reset_bit) begin
      next_timer = 3'h0;
      next_sync  = 1'b0;
    end else if (start) begin
      next_timer = `SLDEC_SYNC_CYCLES - 3'h1;
      next_sync  = 1'b1;
    end else if (sync_timer != 3'h0) begin
      next_timer = sync_timer - 3'h1;
      next_sync  = 1'b1;
    end else begin
      next_timer = 3'h0;
      next_sync  = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pending          <= `SLDEC_RST_BYTE;
      sync_timer       <= 3'h0;
      sync_request_out <= 1'b0;
    end else if (ce) begin
      pending          <= next_pending;
      sync_timer       <= next_timer;
      sync_request_out <= next_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive sequencing after code group sync

  sldec_state_e state, next_state;
  logic [9:0]   mf_count, next_mf;
  logic [9:0]   mf_target;

  // four multiframes per unit of the multiframe count
  assign mf_target = {alignment_multiframe_cnt, 2'b00};

  always_comb begin
    next_state = state;
    next_mf    = mf_count;
    case (state)
      SLDEC_ST_OFF: next_state = SLDEC_ST_CGS;
      SLDEC_ST_CGS: begin
        next_mf = 10'h000;
        if (cgs_achieved) begin
          if (alignment_test_mode) begin
            next_state = SLDEC_ST_ILAS_LOOP;
          end else if (skip_alignment_seq) begin
            next_state = repeat_pattern_test_en ? SLDEC_ST_PATTERN : SLDEC_ST_DATA;
          end else begin
            next_state = SLDEC_ST_ILAS;
          end
        end
      end
      SLDEC_ST_ILAS: begin
        if (mf_boundary) begin
          next_mf = mf_count + 10'h001;
          if (next_mf >= mf_target) begin
            next_state = repeat_pattern_test_en ? SLDEC_ST_PATTERN : SLDEC_ST_DATA;
          end
        end
      end
      SLDEC_ST_ILAS_LOOP: ;
      SLDEC_ST_DATA:      ;
      SLDEC_ST_PATTERN:   ;
      default: next_state = SLDEC_ST_OFF;
    endcase
    if (!cgs_achieved && state != SLDEC_ST_OFF) begin
      next_state = SLDEC_ST_CGS;
    end
    if (soft_reset_bit) begin
      next_state = SLDEC_ST_OFF;
      next_mf    = 10'h000;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state               <= SLDEC_ST_OFF;
      mf_count            <= 10'h000;
      rx_enable           <= 1'b0;
      expect_ilas         <= 1'b0;
      expect_user_data    <= 1'b0;
      pattern_test_active <= 1'b0;
    end else if (ce) begin
      state               <= next_state;
      mf_count            <= next_mf;
      rx_enable           <= (next_state != SLDEC_ST_OFF);
      expect_ilas         <= (next_state == SLDEC_ST_ILAS) | (next_state == SLDEC_ST_ILAS_LOOP);
      expect_user_data    <= (next_state == SLDEC_ST_DATA);
      pattern_test_active <= (next_state == SLDEC_ST_PATTERN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration checksum

  sldec_byte_t chk_sum, next_sum, octet_val;
  logic        next_done, next_err;

  // field boundary map of each configuration octet
  function automatic sldec_byte_t split_of(input logic [3:0] idx);
    case (idx)
      4'h0:    split_of = `SLDEC_SPLIT_0;
      4'h1:    split_of = `SLDEC_SPLIT_1;
      4'h2:    split_of = `SLDEC_SPLIT_2;
      4'h3:    split_of = `SLDEC_SPLIT_3;
      4'h7:    split_of = `SLDEC_SPLIT_7;
      4'h8:    split_of = `SLDEC_SPLIT_8;
      4'h9:    split_of = `SLDEC_SPLIT_9;
      4'hA:    split_of = `SLDEC_SPLIT_10;
      default: split_of = `SLDEC_SPLIT_WHOLE;
    endcase
  endfunction

  // sum of the separate fields packed in one octet
  function automatic sldec_byte_t field_sum(input sldec_byte_t b, input sldec_byte_t split);
    sldec_byte_t total;
    sldec_byte_t field;
    total = 8'h00;
    field = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      field = {field[6:0], b[i]};
      if (split[i]) begin
        total = total + field;
        field = 8'h00;
      end
    end
    return total;
  endfunction

  always_comb begin
    octet_val = checksum_method_sel ? cfg_octet
                                    : field_sum(cfg_octet, split_of(cfg_index));
    next_sum  = chk_sum;
    next_done = 1'b0;
    next_err  = chk_error;
    if (soft_reset_bit) begin
      next_sum = `SLDEC_RST_BYTE;
      next_err = 1'b0;
    end else if (cfg_valid) begin
      if (cfg_index == `SLDEC_CHK_IDX) begin
        next_done = 1'b1;
        next_err  = (cfg_octet != chk_sum);
      end else if (cfg_index == 4'h0) begin
        next_sum = octet_val;
      end else begin
        next_sum = chk_sum + octet_val;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chk_sum   <= `SLDEC_RST_BYTE;
      chk_done  <= 1'b0;
      chk_error <= 1'b0;
    end else if (ce) begin
      chk_sum   <= next_sum;
      chk_done  <= next_done;
      chk_error <= next_err;
    end
  end

endmodule

// ===== verification/sldec_top_asserts.sv
// checker on the deframer error control top ports
// assumes a bind into sldec_top, rising-edge clock, rst_n active low
`timescale 1ns/1ns
module sldec_top_asserts (
  // clock and resets
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        soft_reset_bit,
  // link side
  input wire logic        cgs_achieved,
  input wire logic        cfg_valid,
  input wire logic [3:0]  cfg_index,
  input wire logic [7:0]  bad_disparity_error,
  // status
  input wire logic        rx_enable,
  input wire logic        expect_ilas,
  input wire logic        expect_user_data,
  input wire logic        pattern_test_active,
  input wire logic        chk_done,
  input wire logic [23:0] threshold_event,
  input wire logic        sync_request_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n || soft_reset_bit);
  ////////////////////////////////////////
  // soft reset and receive phases
  a_soft_rx_off: assert property (disable iff (!rst_n) soft_reset_bit |=>
    !rx_enable && !sync_request_out && !expect_ilas && !expect_user_data)
    else $error("soft reset left reception or sync active");
  a_phase_onehot: assert property ($onehot0({expect_ilas, expect_user_data, pattern_test_active}))
    else $error("more than one receive phase active");
  a_cgs_loss_idle: assert property (!cgs_achieved |=>
    !expect_ilas && !expect_user_data && !pattern_test_active)
    else $error("phase kept without code group sync");
  a_user_after_cgs: assert property ($rose(expect_user_data) |-> $past(cgs_achieved))
    else $error("user data phase without code group sync");
  ////////////////////////////////////////
  // error events and sync request shape
  a_event_cause: assert property (threshold_event[0] |-> $past(bad_disparity_error[0]))
    else $error("lane 0 disparity event without an error");
  a_sync_len_four: assert property ($rose(sync_request_out) |->
    sync_request_out [*4] ##1 !sync_request_out)
    else $error("sync request not exactly four cycles");
  ////////////////////////////////////////
  // checksum compare timing
  a_chk_on_last: assert property (cfg_valid && cfg_index == 4'hD |=> chk_done)
    else $error("no checksum result after last octet");
  a_chk_only_last: assert property (chk_done |-> $past(cfg_valid) && $past(cfg_index) == 4'hD)
    else $error("checksum result without last octet");
  // main scenarios reached
  c_sync: cover property ($rose(sync_request_out));
  c_user: cover property ($rose(expect_user_data));
  c_pattern: cover property ($rose(pattern_test_active));
endmodule

// ===== verification/sldec_framer_model.sv
// far-end framer model: code group sync, multiframe boundaries, config octets
// assumes go is driven at the falling edge; slow stretches boundary spacing
`timescale 1ns/1ns
module sldec_framer_model (
  // control
  input  wire logic       clock,
  input  wire logic       go,
  input  wire logic       slow,
  input  wire logic [7:0] chk_val,
  // link
  output logic            cgs_achieved,
  output logic            mf_boundary,
  output logic            cfg_valid,
  output logic [3:0]      cfg_index,
  output logic [7:0]      cfg_octet,
  output logic [7:0]      mf_count
);
  logic [7:0] t;
  logic       pulse;
  ////////////////////////////////////////
  // boundary every 4 or 9 cycles while framing
  assign pulse = go && t != 8'h00 && t % (slow ? 8'h09 : 8'h04) == 8'h00;
  // frame timer, octets 0..13 then endless boundaries
  always_ff @(posedge clock) begin
    cgs_achieved <= go;
    t            <= go ? t + 8'h01 : 8'h00;
    mf_boundary  <= pulse;
    mf_count     <= go ? mf_count + {7'h00, pulse} : 8'h00;
    cfg_valid    <= go && t >= 8'h01 && t <= 8'h0E;
    cfg_index    <= 4'(t - 8'h01);
    cfg_octet    <= t == 8'h02 ? 8'h21 : t == 8'h0E ? chk_val : (t > 8'h0E ? t : 8'h00); // busy pattern
  end
endmodule

// ===== verification/sldec_tb.sv
// self-checking bench: registers, error counts, sync request, phases, checksum
// assumes the framer model and checker are compiled before this file
`timescale 1ns/1ns
module testbench;
  import sldec_pkg::*;
  logic        clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, soft_reset_bit = 0, go = 0, slow = 0;
  logic [11:0] reg_addr = 0;
  sldec_byte_t reg_wdata = 0, reg_rdata, q[$];
  logic [7:0]  cv = 0, bd = 0, nt = 0, uk = 0, m, cfg_octet, mf_count;
  logic        cgs_achieved, mf_boundary, cfg_valid, reg_rdata_valid, rx_enable, expect_ilas, chk_error;
  logic        expect_user_data, pattern_test_active, chk_done, sync_request_out;
  logic [3:0]  cfg_index;
  logic [23:0] threshold_event;
  logic [43:0] e;
  int          seed, sync_hi = 0, evt_n = 0, sb, eb, cyc = 0, fails = 0, total_checks = 0;
  localparam logic [27:0] RT [7] = '{28'h477_00B8, 28'h478_01FF, 28'h47C_FFFF, 28'h47D_0707,
                                     28'h480_3838, 28'h476_0003, 28'h47A_0000};
  localparam logic [43:0] ST [7] = '{44'h00_00_02_07_03_8, 44'h00_00_02_08_21_5, 44'h02_00_01_00_21_5,
    44'h00_80_01_0C_03_8, 44'h03_20_01_00_21_2, 44'h02_A0_01_00_03_8, 44'h00_20_04_10_03_2};
  ////////////////////////////////////////
  always #25 clock = ~clock;
  sldec_top dut (.clock, .rst_n, .ce(1'h1), .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_rdata_valid, .soft_reset_bit, .cgs_achieved, .mf_boundary, .cfg_valid, .cfg_index, .cfg_octet,
    .bad_disparity_error(bd), .not_in_table_error(nt), .unexpected_control_char_error(uk), .rx_enable,
    .expect_ilas, .expect_user_data, .pattern_test_active, .chk_done, .chk_error, .threshold_event,
    .sync_request_out);
  sldec_framer_model far_end (.clock, .go, .slow, .chk_val(cv), .cgs_achieved, .mf_boundary,
    .cfg_valid, .cfg_index, .cfg_octet, .mf_count);
  ////////////////////////////////////////
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      fails++;
      $display("[ERR] %s exp %0h seen %0h", n, x, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wreg(logic [11:0] a, logic [7:0] d);
    @(negedge clock);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'h1};
    @(negedge clock);
    reg_wr = 1'h0;
  endtask
  task automatic rreg(logic [11:0] a, logic [7:0] x);
    @(negedge clock);
    {reg_addr, reg_rd} = {a, 1'h1};
    q.push_back(x);
    @(negedge clock);
    reg_rd = 1'h0;
  endtask
  // configuration only while the deframer is held in soft reset
  task automatic setup(logic [7:0] c1, c2, thr, msk, en, kv);
    @(negedge clock);
    soft_reset_bit = 1'h1;
    wreg(12'h476, c1);
    wreg(12'h477, c2);
    wreg(12'h478, kv);
    wreg(12'h47C, thr);
    wreg(12'h47D, msk);
    wreg(12'h480, en);
    @(negedge clock);
    soft_reset_bit = 1'h0;
    sb = sync_hi;
    eb = evt_n;
  endtask
  task automatic hit(logic [7:0] b, n, u);
    @(negedge clock);
    {bd, nt, uk} = {b, n, u};
    @(negedge clock);
    {bd, nt, uk} = '0;
    repeat (10) @(negedge clock);
  endtask
  task automatic settle(int rep, int evt);
    repeat (50) @(negedge clock);
    chk("sync cycles", sync_hi - sb, 4 * rep);
    chk("events", evt_n - eb, evt);
  endtask
  // read results off the queue, tally sync and events, cut hangs
  always @(negedge clock) begin
    cyc++;
    sync_hi += int'(sync_request_out === 1'h1);
    evt_n += $countones(threshold_event);
    if (reg_rdata_valid === 1'h1)
      chk("reg read", reg_rdata, q.pop_front());
    if (cyc == 5000) begin
      fails++;
      close_out();
    end
  end
  // main sequence
  initial begin
    seed = 32'hD98558B0;
    repeat (12) @(negedge clock);
    rst_n = 1'h1;
    foreach (RT[i]) rreg(RT[i][27:16], RT[i][15:8]);
    @(negedge clock);
    soft_reset_bit = 1'h1;
    foreach (RT[i]) begin
      wreg(RT[i][27:16], 8'hFF);
      rreg(RT[i][27:16], RT[i][7:0]);
    end
    m = 8'($random(seed)) | 8'h01;
    setup(8'h00, 8'h00, 8'h01, 8'h07, 8'h38, 8'h01);
    hit(m, 8'h00, 8'h00);
    hit(8'h01, 8'h00, 8'h00);
    settle(1, $countones(m));
    setup(8'h00, 8'h10, 8'h01, 8'h07, 8'h38, 8'h01);
    hit(m, 8'h00, 8'h00);
    settle($countones(m), $countones(m));
    setup(8'h00, 8'h08, 8'h01, 8'h07, 8'h38, 8'h01);
    hit(8'h01, 8'h00, 8'h00);
    hit(8'h01, 8'h00, 8'h00);
    settle(2, 2);
    setup(8'h00, 8'h00, 8'h01, 8'h03, 8'h38, 8'h01);
    hit(8'h01, 8'h00, 8'h00);
    hit(8'h00, 8'h01, 8'h00);
    settle(1, 2);
    setup(8'h00, 8'h00, 8'h01, 8'h07, 8'h30, 8'h01);
    hit(8'h01, 8'h00, 8'h00);
    hit(8'h02, 8'h00, 8'h00);
    settle(1, 1);
    setup(8'h00, 8'h00, 8'h02, 8'h07, 8'h38, 8'h01);
    hit(8'h00, 8'h00, 8'h01);
    hit(8'h00, 8'h00, 8'h01);
    settle(1, 1);
    for (int i = 0; i < 7; i++) begin
      e = ST[i];
      setup(e[43:36], e[35:28], 8'hFF, 8'h07, 8'h38, e[27:20]);
      cv = e[11:4];
      slow = i[0];
      @(negedge clock);
      go = 1'h1;
      repeat (2) @(negedge clock);
      while (mf_count != e[19:12]) @(negedge clock);
      repeat (2) @(negedge clock);
      chk("phase", {rx_enable, expect_ilas, expect_user_data, pattern_test_active},
          {1'h1, e[3:1]});
      repeat (20) @(negedge clock);
      chk("checksum", chk_error, e[0]);
      go = 1'h0;
    end
    chk("read queue", q.size(), 0);
    close_out();
  end
endmodule
bind sldec_top sldec_top_asserts u_chk (.clock, .rst_n, .soft_reset_bit, .cgs_achieved, .cfg_valid,
  .cfg_index, .bad_disparity_error, .rx_enable, .expect_ilas, .expect_user_data, .pattern_test_active,
  .chk_done, .threshold_event, .sync_request_out);
